// ### design/timer_consts.svh
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets on the byte-wide register port
// ----------------------------------------------------------------
`define OFS_CONTROL   8'h00
`define OFS_MODE      8'h01
`define OFS_CLKSEL    8'h02
`define OFS_A_LOW     8'h03
`define OFS_A_HIGH    8'h04
`define OFS_B_LOW     8'h05
`define OFS_B_HIGH    8'h06
`define OFS_IRQ_EN    8'h07
`define OFS_EXT_CFG   8'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTL_B_FLAG    7
`define CTL_B_RUN     6
`define CTL_A_FLAG    5
`define CTL_A_RUN     4
`define MOD_B_GATE    7
`define MOD_B_CSEL    6
`define MOD_B_LSB     4
`define MOD_A_GATE    3
`define MOD_A_CSEL    2
`define MOD_A_LSB     0
`define CKS_B_SYS     3
`define CKS_A_SYS     2
`define CKS_PRE_LSB   0
`define IEN_A         1
`define IEN_B         3
`define EXT_A_POL     3
`define EXT_B_POL     7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE      8'h00
`define RST_PRE_CNT   6'h00

// ----------------------------------------------------------------
// prescaler divide ratios, minus one
// ----------------------------------------------------------------
`define PRE_LIM_0     6'h0b
`define PRE_LIM_1     6'h03
`define PRE_LIM_2     6'h2f
`define PRE_LIM_3     6'h07

// ----------------------------------------------------------------
// pin sampling: levels must hold this many system clocks
// ----------------------------------------------------------------
`define PIN_HOLD_CYCLES 2

`endif

// ### design/timer_pkg.sv
`default_nettype none
package timer_pkg;

	typedef enum logic [1:0] {
		MODE_13     = 2'b00,
		MODE_16     = 2'b01,
		MODE_RELOAD = 2'b10,
		MODE_OFF    = 2'b11
	} tmode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	// bit order of the pin vector: 0 count a, 1 count b, 2 gate a, 3 gate b
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] level;
		logic [3:0] fall;
	} sync_st_t;

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic       ovf;
	} unit_st_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [7:0] clksel;
		logic [7:0] irq_en;
		logic [7:0] ext_cfg;
		logic [7:0] rdata;
		logic       irq_a;
		logic       irq_b;
		logic [5:0] pre_cnt;
		logic       pre_tick;
	} main_st_t;

endpackage
`default_nettype wire

// ### design/pin_sync.sv
`default_nettype none
module pin_sync (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] pins,
	output logic      [3:0] level,
	output logic      [3:0] fall
);
	import timer_pkg::*;

	sync_st_t st;
	sync_st_t next_st;

	// a level is accepted only once stages two and three agree
	always_comb begin
		next_st       = st;
		next_st.s1    = pins;
		next_st.s2    = st.s1;
		next_st.s3    = st.s2;
		next_st.fall  = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.level[i] = st.s3[i];
				next_st.fall[i]  = st.level[i] & ~st.s3[i];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{s1: 4'hf, s2: 4'hf, s3: 4'hf, level: 4'hf, fall: 4'h0};
		end else begin
			st <= next_st;
		end
	end

	assign level = st.level;
	assign fall  = st.fall;
endmodule // pin_sync
`default_nettype wire

// ### design/timer_unit.sv
`default_nettype none
module timer_unit (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             tick,
	input  wire timer_pkg::tmode_t mode,
	input  wire logic             wr_low,
	input  wire logic             wr_high,
	input  wire logic [7:0]       wdata,
	output logic      [7:0]       low,
	output logic      [7:0]       high,
	output logic                  ovf
);
	import timer_pkg::*;

	unit_st_t st;
	unit_st_t next_st;

	always_comb begin
		logic [12:0] cnt13;
		logic [15:0] cnt16;
		cnt13       = {st.high, st.low[4:0]} + 13'h0001;
		cnt16       = {st.high, st.low} + 16'h0001;
		next_st     = st;
		next_st.ovf = 1'b0;
		// a software write beats a count in the same cycle
		if (wr_low || wr_high) begin
			if (wr_low) begin
				next_st.low = wdata;
			end
			if (wr_high) begin
				next_st.high = wdata;
			end
		end else if (tick) begin
			unique case (mode)
				MODE_13: begin
					// upper three low-byte bits are left as they were
					next_st.high = cnt13[12:5];
					next_st.low  = {st.low[7:5], cnt13[4:0]};
					next_st.ovf  = (cnt13 == 13'h0000);
				end
				MODE_16: begin
					next_st.high = cnt16[15:8];
					next_st.low  = cnt16[7:0];
					next_st.ovf  = (cnt16 == 16'h0000);
				end
				MODE_RELOAD: begin
					if (st.low == 8'hff) begin
						next_st.low = st.high;
						next_st.ovf = 1'b1;
					end else begin
						next_st.low = st.low + 8'h01;
					end
				end
				MODE_OFF: begin
					next_st.ovf = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{low: 8'h00, high: 8'h00, ovf: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign low  = st.low;
	assign high = st.high;
	assign ovf  = st.ovf;
endmodule // timer_unit
`default_nettype wire

// ### design/dual_counter_timer.sv
`include "timer_consts.svh"
`default_nettype none
module dual_counter_timer (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire timer_pkg::reg_req_t req,
	output logic      [7:0]          rdata,
	input  wire logic                timer_a_count_pin,
	input  wire logic                timer_b_count_pin,
	input  wire logic                gate_input_a,
	input  wire logic                gate_input_b,
	input  wire logic                irq_ack_a,
	input  wire logic                irq_ack_b,
	output logic                     timer_a_irq,
	output logic                     timer_b_irq
);
	import timer_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	function automatic logic [5:0] pre_limit(input logic [1:0] f);
		logic [5:0] lim;
		lim = `PRE_LIM_0;
		unique case (f)
			2'b00: lim = `PRE_LIM_0;
			2'b01: lim = `PRE_LIM_1;
			2'b10: lim = `PRE_LIM_2;
			2'b11: lim = `PRE_LIM_3;
		endcase
		return lim;
	endfunction

	main_st_t   st;
	main_st_t   next_st;
	logic [3:0] pin_level;
	logic [3:0] pin_fall;
	logic [7:0] a_low;
	logic [7:0] a_high;
	logic [7:0] b_low;
	logic [7:0] b_high;
	logic       a_ovf;
	logic       b_ovf;
	logic       a_tick;
	logic       b_tick;
	logic       a_run;
	logic       b_run;
	tmode_t     a_mode;
	tmode_t     b_mode;
	logic       wr_ctrl;

	// ------------------------------------------------------------
	// pin sampling
	// ------------------------------------------------------------
	// three stages keep the count from seeing a metastable edge,
	// which is why pins must hold each level two clocks
	pin_sync u_sync (
		.clk   (clk),
		.rst   (rst),
		.pins  ({gate_input_b, gate_input_a,
			timer_b_count_pin, timer_a_count_pin}),
		.level (pin_level),
		.fall  (pin_fall)
	);

	// ------------------------------------------------------------
	// increment sources and gating
	// ------------------------------------------------------------
	assign a_mode  = tmode_t'(st.mode[`MOD_A_LSB +: 2]);
	assign b_mode  = tmode_t'(st.mode[`MOD_B_LSB +: 2]);
	assign wr_ctrl = req.wr && hit(req.addr, `OFS_CONTROL);

	always_comb begin
		logic a_gate_ok;
		logic b_gate_ok;
		logic a_src;
		logic b_src;
		a_src     = 1'b0;
		b_src     = 1'b0;
		a_gate_ok = (pin_level[2] == st.ext_cfg[`EXT_A_POL]);
		b_gate_ok = (pin_level[3] == st.ext_cfg[`EXT_B_POL]);
		// the run bit only gates; it never touches the count
		a_run = st.ctrl[`CTL_A_RUN] &&
			(!st.mode[`MOD_A_GATE] || a_gate_ok);
		b_run = st.ctrl[`CTL_B_RUN] &&
			(!st.mode[`MOD_B_GATE] || b_gate_ok);
		if (st.mode[`MOD_A_CSEL]) begin
			a_src = pin_fall[0];
		end else begin
			a_src = st.clksel[`CKS_A_SYS] || st.pre_tick;
		end
		if (st.mode[`MOD_B_CSEL]) begin
			b_src = pin_fall[1];
		end else begin
			b_src = st.clksel[`CKS_B_SYS] || st.pre_tick;
		end
		a_tick = a_run && a_src;
		b_tick = b_run && b_src;
	end

	// ------------------------------------------------------------
	// the two counters
	// ------------------------------------------------------------
	timer_unit u_timer_a (
		.clk     (clk),
		.rst     (rst),
		.tick    (a_tick),
		.mode    (a_mode),
		.wr_low  (req.wr && hit(req.addr, `OFS_A_LOW)),
		.wr_high (req.wr && hit(req.addr, `OFS_A_HIGH)),
		.wdata   (req.wdata),
		.low     (a_low),
		.high    (a_high),
		.ovf     (a_ovf)
	);

	timer_unit u_timer_b (
		.clk     (clk),
		.rst     (rst),
		.tick    (b_tick),
		.mode    (b_mode),
		.wr_low  (req.wr && hit(req.addr, `OFS_B_LOW)),
		.wr_high (req.wr && hit(req.addr, `OFS_B_HIGH)),
		.wdata   (req.wdata),
		.low     (b_low),
		.high    (b_high),
		.ovf     (b_ovf)
	);

	// ------------------------------------------------------------
	// registers, flags, prescaler
	// ------------------------------------------------------------
	always_comb begin
		logic a_flag;
		logic b_flag;
		a_flag           = 1'b0;
		b_flag           = 1'b0;
		next_st          = st;
		next_st.rdata    = 8'h00;
		next_st.pre_tick = 1'b0;
		// shared prescaler: one-cycle enable every limit+1 clocks
		if (st.pre_cnt >= pre_limit(st.clksel[`CKS_PRE_LSB +: 2])) begin
			next_st.pre_cnt  = `RST_PRE_CNT;
			next_st.pre_tick = 1'b1;
		end else begin
			next_st.pre_cnt = st.pre_cnt + 6'h01;
		end
		if (req.wr) begin
			if (hit(req.addr, `OFS_CONTROL)) next_st.ctrl = req.wdata;
			if (hit(req.addr, `OFS_MODE)) next_st.mode = req.wdata;
			if (hit(req.addr, `OFS_CLKSEL)) next_st.clksel = req.wdata;
			if (hit(req.addr, `OFS_IRQ_EN)) next_st.irq_en = req.wdata;
			if (hit(req.addr, `OFS_EXT_CFG)) next_st.ext_cfg = req.wdata;
		end
		// clear by write or by vector, but a new overflow wins
		a_flag = wr_ctrl ? req.wdata[`CTL_A_FLAG] : st.ctrl[`CTL_A_FLAG];
		b_flag = wr_ctrl ? req.wdata[`CTL_B_FLAG] : st.ctrl[`CTL_B_FLAG];
		next_st.ctrl[`CTL_A_FLAG] = a_ovf || (a_flag && !irq_ack_a);
		next_st.ctrl[`CTL_B_FLAG] = b_ovf || (b_flag && !irq_ack_b);
		next_st.irq_a = next_st.ctrl[`CTL_A_FLAG] &&
			next_st.irq_en[`IEN_A];
		next_st.irq_b = next_st.ctrl[`CTL_B_FLAG] &&
			next_st.irq_en[`IEN_B];
		if (req.rd) begin
			unique case (req.addr)
				`OFS_CONTROL: next_st.rdata = st.ctrl;
				`OFS_MODE:    next_st.rdata = st.mode;
				`OFS_CLKSEL:  next_st.rdata = st.clksel;
				`OFS_A_LOW:   next_st.rdata = a_low;
				`OFS_A_HIGH:  next_st.rdata = a_high;
				`OFS_B_LOW:   next_st.rdata = b_low;
				`OFS_B_HIGH:  next_st.rdata = b_high;
				`OFS_IRQ_EN:  next_st.rdata = st.irq_en;
				`OFS_EXT_CFG: next_st.rdata = st.ext_cfg;
				default:      next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{ctrl: `RST_BYTE, mode: `RST_BYTE, clksel: `RST_BYTE,
				irq_en: `RST_BYTE, ext_cfg: `RST_BYTE, rdata: `RST_BYTE,
				irq_a: 1'b0, irq_b: 1'b0, pre_cnt: `RST_PRE_CNT,
				pre_tick: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign rdata       = st.rdata;
	assign timer_a_irq = st.irq_a;
	assign timer_b_irq = st.irq_b;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic a_free_sys;
	assign a_free_sys = st.ctrl[`CTL_A_RUN] && !st.mode[`MOD_A_GATE] &&
		!st.mode[`MOD_A_CSEL] && st.clksel[`CKS_A_SYS];

	chk_halt_holds: assert property (
		(!st.ctrl[`CTL_A_RUN] && !req.wr) |=> $stable({a_high, a_low}))
		else $error("timer a moved while stopped");

	chk_sys_rate: assert property (
		(a_free_sys && a_mode == MODE_16 && !req.wr) |=>
		({a_high, a_low} == 16'($past({a_high, a_low}) + 16'h0001)))
		else $error("timer a missed a system clock count");

	chk_wrap_13: assert property (
		(a_tick && a_mode == MODE_13 && !req.wr && !irq_ack_a &&
		{a_high, a_low[4:0]} == 13'h1fff)
		|=> a_ovf ##1 st.ctrl[`CTL_A_FLAG])
		else $error("13-bit wrap did not raise the flag");

	chk_reload_copy: assert property (
		(a_tick && a_mode == MODE_RELOAD && a_low == 8'hff && !req.wr)
		|=> (a_low == $past(a_high)) && a_ovf)
		else $error("auto-reload did not copy the high byte");

	chk_reload_high: assert property (
		(a_mode == MODE_RELOAD && !req.wr) |=> $stable(a_high))
		else $error("reload value changed");

	chk_edge_only: assert property (
		(st.mode[`MOD_A_CSEL] && !pin_fall[0] && !req.wr)
		|=> $stable({a_high, a_low}))
		else $error("counter moved without a pin edge");

	chk_irq_enable: assert property (
		timer_a_irq |-> ($past(st.irq_en[`IEN_A]) || $past(req.wr))
		&& st.ctrl[`CTL_A_FLAG])
		else $error("interrupt raised while disabled");

	chk_ack_clears: assert property (
		(irq_ack_a && !a_ovf && !wr_ctrl) |=>
		(!st.ctrl[`CTL_A_FLAG] && !timer_a_irq))
		else $error("vector acknowledge left the flag set");

	chk_off_idle: assert property (
		(a_mode == MODE_OFF && !req.wr) |=>
		(!a_ovf && $stable({a_high, a_low})))
		else $error("inactive timer moved or reported overflow");

	chk_upper_kept: assert property (
		(a_mode == MODE_13 && !req.wr) |=> $stable(a_low[7:5]))
		else $error("13-bit count disturbed the upper low-byte bits");

	chk_set_wins: assert property (
		a_ovf |=> st.ctrl[`CTL_A_FLAG])
		else $error("overflow did not set flag a");

	chk_b_halt: assert property (
		(!st.ctrl[`CTL_B_RUN] && !req.wr) |=> $stable({b_high, b_low}))
		else $error("timer b moved while stopped");

	chk_gate_blocks: assert property (
		(st.mode[`MOD_B_GATE] && !req.wr &&
		pin_level[3] != st.ext_cfg[`EXT_B_POL])
		|=> $stable({b_high, b_low}))
		else $error("timer b counted with its gate inactive");

	chk_pin_source: assert property (
		(st.mode[`MOD_B_CSEL] && !pin_fall[1] && !req.wr)
		|=> $stable({b_high, b_low}))
		else $error("timer b moved without a pin edge");

	chk_b_wrap_16: assert property (
		(b_tick && b_mode == MODE_16 && !req.wr &&
		{b_high, b_low} == 16'hffff)
		|=> b_ovf ##1 st.ctrl[`CTL_B_FLAG])
		else $error("16-bit wrap did not raise flag b");

	chk_read_bytes: assert property (
		(req.rd && req.addr == `OFS_B_HIGH) |=> rdata == $past(b_high))
		else $error("high byte read returned the wrong value");
endmodule // dual_counter_timer
`default_nettype wire

// ### testbench/pin_model.sv
`default_nettype none
module pin_model (
	input  wire logic clk,
	output logic      count_a,
	output logic      count_b,
	output logic      gate_a,
	output logic      gate_b
);
	timeunit 1ns;
	timeprecision 1ns;

	// pins idle high, gates start low
	initial begin
		count_a = 1'b1;
		count_b = 1'b1;
		gate_a  = 1'b0;
		gate_b  = 1'b0;
	end

	// -----------------------------------------------
	// falling edges on a count pin
	// -----------------------------------------------
	// a four-clock period is the fastest rate the sampler accepts
	task automatic pulses(input logic sel, input int n);
		@(posedge clk);
		for (int i = 0; i < n; i++) begin
			if (sel)
				count_b <= 1'b0;
			else
				count_a <= 1'b0;
			repeat (2) @(posedge clk);
			if (sel)
				count_b <= 1'b1;
			else
				count_a <= 1'b1;
			repeat (2) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask

	// -----------------------------------------------
	// gate level, left to settle through the sampler
	// -----------------------------------------------
	task automatic set_gate(input logic sel, input logic lvl);
		@(posedge clk);
		if (sel)
			gate_b <= lvl;
		else
			gate_a <= lvl;
		repeat (6) @(posedge clk);
	endtask
endmodule // pin_model
`default_nettype wire

// ### testbench/dual_counter_timer_tb_top.sv
`include "timer_consts.svh"
`default_nettype none
module dual_counter_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import timer_pkg::*;

	logic       clk;
	logic       rst;
	reg_req_t   req;
	logic [7:0] rdata;
	logic       pin_ca;
	logic       pin_cb;
	logic       pin_ga;
	logic       pin_gb;
	logic       ack_a;
	logic       ack_b;
	logic       irq_a;
	logic       irq_b;
	int         err_count = 0;
	int         num_checks = 0;
	int         cycles = 0;
	logic [7:0] v;
	logic [7:0] w;
	logic [7:0] srcs [5] = '{8'h08, 8'h00, 8'h01, 8'h02, 8'h03};
	logic [7:0] steps [5] = '{8'h60, 8'h08, 8'h18, 8'h02, 8'h0c};

	dual_counter_timer dual_counter_timer_inst (
		.clk              (clk),
		.rst              (rst),
		.req              (req),
		.rdata            (rdata),
		.timer_a_count_pin(pin_ca),
		.timer_b_count_pin(pin_cb),
		.gate_input_a     (pin_ga),
		.gate_input_b     (pin_gb),
		.irq_ack_a        (ack_a),
		.irq_ack_b        (ack_b),
		.timer_a_irq      (irq_a),
		.timer_b_irq      (irq_b)
	);

	pin_model pin_model_inst (
		.clk    (clk),
		.count_a(pin_ca),
		.count_b(pin_cb),
		.gate_a (pin_ga),
		.gate_b (pin_gb)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// -----------------------------------------------
	// closing and timeout
	// -----------------------------------------------
	task automatic final_report();
		if (err_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end

	// -----------------------------------------------
	// register port and comparisons
	// -----------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic check8(input string n, input logic [7:0] e,
			input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic check1(input string n, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic expect_reg(input logic [7:0] a, input logic [7:0] m,
			input logic [7:0] e, input string n);
		logic [7:0] d;
		rd(a, d);
		check8(n, e, d & m);
	endtask

	// -----------------------------------------------
	// main sequence
	// -----------------------------------------------
	initial begin
		rst = 1'b1;
		req = '0;
		ack_a = 1'b0;
		ack_b = 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		expect_reg(`OFS_CONTROL, 8'hff, 8'h00, "control");
		expect_reg(`OFS_MODE, 8'hff, 8'h00, "mode");
		expect_reg(`OFS_A_LOW, 8'hff, 8'h00, "a low");
		wr(8'h20, 8'h5a);
		expect_reg(8'h20, 8'hff, 8'h00, "unmapped");
		// 13-bit counter on pin a, wrap from all ones
		wr(`OFS_MODE, 8'h04);
		wr(`OFS_A_HIGH, 8'hff);
		wr(`OFS_A_LOW, 8'hfd);
		wr(`OFS_CONTROL, 8'h10);
		pin_model_inst.pulses(1'b0, 3);
		expect_reg(`OFS_A_HIGH, 8'hff, 8'h00, "a high");
		expect_reg(`OFS_A_LOW, 8'h1f, 8'h00, "a low");
		expect_reg(`OFS_CONTROL, 8'h20, 8'h20, "flag a");
		check1("irq a", 1'b0, irq_a);
		@(posedge clk);
		ack_a <= 1'b1;
		@(posedge clk);
		ack_a <= 1'b0;
		expect_reg(`OFS_CONTROL, 8'h20, 8'h00, "flag a");
		// 16-bit counter b behind its gate
		wr(`OFS_IRQ_EN, 8'h0a);
		wr(`OFS_EXT_CFG, 8'h80);
		wr(`OFS_MODE, 8'hd4);
		wr(`OFS_B_HIGH, 8'hff);
		wr(`OFS_B_LOW, 8'hfe);
		wr(`OFS_CONTROL, 8'h40);
		pin_model_inst.pulses(1'b1, 2);
		expect_reg(`OFS_B_LOW, 8'hff, 8'hfe, "b low");
		pin_model_inst.set_gate(1'b1, 1'b1);
		pin_model_inst.pulses(1'b1, 2);
		expect_reg(`OFS_B_HIGH, 8'hff, 8'h00, "b high");
		expect_reg(`OFS_B_LOW, 8'hff, 8'h00, "b low");
		expect_reg(`OFS_CONTROL, 8'h80, 8'h80, "flag b");
		check1("irq b", 1'b1, irq_b);
		// flag b goes by acknowledge; flag a goes by a write below
		@(posedge clk);
		ack_b <= 1'b1;
		@(posedge clk);
		ack_b <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check1("irq b", 1'b0, irq_b);
		expect_reg(`OFS_CONTROL, 8'h80, 8'h00, "flag b");
		wr(`OFS_EXT_CFG, 8'h00);
		pin_model_inst.pulses(1'b1, 1);
		expect_reg(`OFS_B_LOW, 8'hff, 8'h00, "b low");
		pin_model_inst.set_gate(1'b1, 1'b0);
		pin_model_inst.pulses(1'b1, 1);
		expect_reg(`OFS_B_LOW, 8'hff, 8'h01, "b low");
		// 8-bit auto-reload on pin a
		wr(`OFS_MODE, 8'h06);
		wr(`OFS_A_HIGH, 8'h80);
		wr(`OFS_A_LOW, 8'hfe);
		wr(`OFS_CONTROL, 8'h10);
		pin_model_inst.pulses(1'b0, 3);
		expect_reg(`OFS_A_LOW, 8'hff, 8'h81, "a low");
		expect_reg(`OFS_A_HIGH, 8'hff, 8'h80, "a high");
		expect_reg(`OFS_CONTROL, 8'h20, 8'h20, "flag a");
		check1("irq a", 1'b1, irq_a);
		// inactive mode ignores edges
		wr(`OFS_MODE, 8'h07);
		wr(`OFS_CONTROL, 8'h10);
		pin_model_inst.pulses(1'b0, 2);
		expect_reg(`OFS_A_LOW, 8'hff, 8'h81, "a low");
		check1("irq a", 1'b0, irq_a);
		// timer b over a 96-cycle window for each clock source
		wr(`OFS_MODE, 8'h10);
		wr(`OFS_CONTROL, 8'h40);
		for (int i = 0; i < 5; i++) begin
			wr(`OFS_CLKSEL, srcs[i]);
			rd(`OFS_B_LOW, v);
			repeat (94) @(posedge clk);
			rd(`OFS_B_LOW, w);
			check8("b step", steps[i], 8'(w - v));
		end
		// timer a, 16-bit on the system clock
		wr(`OFS_MODE, 8'h01);
		wr(`OFS_CLKSEL, 8'h04);
		wr(`OFS_CONTROL, 8'h10);
		rd(`OFS_A_LOW, v);
		repeat (94) @(posedge clk);
		rd(`OFS_A_LOW, w);
		check8("a step", 8'h60, 8'(w - v));
		final_report();
	end
endmodule // dual_counter_timer_tb_top
`default_nettype wire
